// ---- hpp_host_port.sv ----
// parallel host port: pin decode, clear-on-read status, interrupt pin
//
// Contract
// - style select 00 gives separate active-low read and write strobes.
// - style select 01 gives one data strobe plus read/write direction.
// - eight address inputs decode up to 256 byte locations directly.
// - all transfers use an eight-bit two-way data bus.
// - address and data stay on separate pins, never multiplexed.
// - chip select low needed for access; strobes ignored while it is high.
// - split style: read strobe pulse reads, write strobe pulse writes.
// - strobe style: strobe pulse reads if direction high, writes if low.
// - interrupt pin pulled low while any unmasked condition is pending.
// - latched status bits clear when host reads their register.
// - event coinciding with the clearing read stays latched.
// - drive-high select set drives inactive interrupt high, else floats.
// - after reset interrupt pin floats until an unmasked source is first pending.
// - host port is twenty-one signals: address, data, select, strobes, style.
// - while reset is asserted every host bus output is high impedance.
`timescale 1ns/1ps

module hpp_host_port #(
  parameter int STAT_REGS = hpp_pkg::STAT_REGS
) (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  // host pins
  input  wire logic [7:0]                   addr,
  input  wire logic [7:0]                   data_in,
  output      logic [7:0]                   data_out,
  output      logic                         data_oe_n,
  input  wire logic                         cs_n,
  input  wire logic                         rd_data_strobe_n,
  input  wire logic                         wr_rw_n,
  input  wire logic [1:0]                   bus_style_select,
  output      logic                         irq_n_out,
  output      logic                         irq_n_oe_n,
  // device register side
  output      logic [7:0]                   reg_addr,
  output      logic [7:0]                   reg_wdata,
  output      logic                         reg_wr,
  output      logic                         reg_rd,
  input  wire logic [7:0]                   reg_rdata,
  // status sources and control
  input  wire logic [STAT_REGS*8-1:0]       stat_event,
  input  wire logic [STAT_REGS*8-1:0]       stat_mask,
  input  wire logic                         irq_drive_high_select
);

  if (STAT_REGS < 1 || STAT_REGS > 16) begin : g_bad_stat_regs
    $error("STAT_REGS out of range");
  end

  // ---------------------------------------------------------------
  // pin synchronisers and agreement filter
  // ---------------------------------------------------------------
  hpp_pkg::hpp_pins_s pin_raw;
  hpp_pkg::hpp_pins_s s1_q;
  hpp_pkg::hpp_pins_s s2_q;
  hpp_pkg::hpp_pins_s s3_q;
  hpp_pkg::hpp_pins_s pin_q;

  assign pin_raw = '{cs_n: cs_n, rd_ds_n: rd_data_strobe_n,
                     wr_rw_n: wr_rw_n, bus_style_select: bus_style_select,
                     addr: addr, data: data_in};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= hpp_pkg::PINS_IDLE;
      s2_q <= hpp_pkg::PINS_IDLE;
      s3_q <= hpp_pkg::PINS_IDLE;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < $bits(hpp_pkg::hpp_pins_s); gb++) begin : g_filt
      always_ff @(posedge sys_clk) begin
        if (rst)
          pin_q[gb] <= hpp_pkg::PINS_IDLE[gb];
        else if (s2_q[gb] == s3_q[gb])
          pin_q[gb] <= s3_q[gb];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic is_split;
  logic is_strobe;
  logic rd_act;
  logic wr_act;

  assign is_split  = pin_q.bus_style_select == hpp_pkg::STYLE_SPLIT;
  assign is_strobe = pin_q.bus_style_select == hpp_pkg::STYLE_STROBE;
  always_comb begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (!pin_q.cs_n) begin
      if (is_split) begin
        rd_act = !pin_q.rd_ds_n;
        wr_act = !pin_q.wr_rw_n && pin_q.rd_ds_n;
      end else if (is_strobe) begin
        rd_act = !pin_q.rd_ds_n && pin_q.wr_rw_n;
        wr_act = !pin_q.rd_ds_n && !pin_q.wr_rw_n;
      end
    end
  end

  // ---------------------------------------------------------------
  // access state machine
  // ---------------------------------------------------------------
  hpp_pkg::hpp_state_e state_q;
  hpp_pkg::hpp_state_e state_d;
  logic                rd_start;

  always_comb begin
    state_d = state_q;
    case (state_q)
      hpp_pkg::ST_IDLE: begin
        if (rd_act)
          state_d = hpp_pkg::ST_READ;
        else if (wr_act)
          state_d = hpp_pkg::ST_WRITE;
      end
      hpp_pkg::ST_READ: begin
        if (!rd_act)
          state_d = hpp_pkg::ST_IDLE;
      end
      hpp_pkg::ST_WRITE: begin
        if (!wr_act)
          state_d = hpp_pkg::ST_IDLE;
      end
      default: state_d = hpp_pkg::ST_IDLE;
    endcase
  end

  assign rd_start = state_q == hpp_pkg::ST_IDLE && rd_act;

  always_ff @(posedge sys_clk) begin
    if (rst)
      state_q <= hpp_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // ---------------------------------------------------------------
  // register side strobes
  // ---------------------------------------------------------------
  logic       wr_end;
  logic [7:0] reg_addr_q;
  logic [7:0] reg_wdata_q;
  logic       reg_wr_q;
  logic       reg_rd_q;

  assign wr_end = state_q == hpp_pkg::ST_WRITE && !wr_act;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_addr_q  <= 8'h00;
      reg_wdata_q <= 8'h00;
    end else if (!wr_end) begin
      reg_addr_q  <= pin_q.addr;
      reg_wdata_q <= pin_q.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
    end else begin
      reg_wr_q <= wr_end;
      reg_rd_q <= rd_start;
    end
  end

  assign reg_addr  = reg_addr_q;
  assign reg_wdata = reg_wdata_q;
  assign reg_wr    = reg_wr_q;
  assign reg_rd    = reg_rd_q;

  // ---------------------------------------------------------------
  // latched status, clear on read
  // ---------------------------------------------------------------
  logic [STAT_REGS*8-1:0] stat_q;
  logic [STAT_REGS-1:0]   stat_hit;
  logic [STAT_REGS-1:0]   stat_pend;
  logic [7:0]             stat_rd;

  genvar gs;
  generate
    for (gs = 0; gs < STAT_REGS; gs++) begin : g_stat
      assign stat_hit[gs]  = reg_addr_q == hpp_pkg::STAT_BASE + 8'(gs);
      assign stat_pend[gs] = |(stat_q[gs*8 +: 8] & stat_mask[gs*8 +: 8]);
      always_ff @(posedge sys_clk) begin
        if (rst)
          stat_q[gs*8 +: 8] <= hpp_pkg::STAT_RST;
        else if (rd_start && stat_hit[gs])
          stat_q[gs*8 +: 8] <= stat_event[gs*8 +: 8];
        else
          stat_q[gs*8 +: 8] <= stat_q[gs*8 +: 8] | stat_event[gs*8 +: 8];
      end

      property p_clear_on_read;
        @(posedge sys_clk) disable iff (rst)
        rd_start && stat_hit[gs] && stat_event[gs*8 +: 8] == 8'h00
        |=> stat_q[gs*8 +: 8] == 8'h00;
      endproperty
      a_clear_on_read: assert property (p_clear_on_read)
        else $error("status not cleared by read");
      property p_event_kept;
        @(posedge sys_clk) disable iff (rst)
        rd_start && stat_hit[gs]
        |=> (stat_q[gs*8 +: 8] & $past(stat_event[gs*8 +: 8]))
            == $past(stat_event[gs*8 +: 8]);
      endproperty
      a_event_kept: assert property (p_event_kept)
        else $error("coincident status event lost");
    end
  endgenerate

  always_comb begin
    stat_rd = 8'h00;
    for (int i = 0; i < STAT_REGS; i++) begin
      if (stat_hit[i])
        stat_rd = stat_q[i*8 +: 8];
    end
  end

  // ---------------------------------------------------------------
  // read data and bus drive
  // ---------------------------------------------------------------
  logic [7:0] data_q;

  always_ff @(posedge sys_clk) begin
    if (rst)
      data_q <= 8'h00;
    else if (rd_start)
      data_q <= (|stat_hit) ? stat_rd : reg_rdata;
    else if (state_q == hpp_pkg::ST_READ && !(|stat_hit))
      data_q <= reg_rdata;
  end

  assign data_out  = data_q;
  assign data_oe_n = rst || !(state_q == hpp_pkg::ST_READ && rd_act);

  // ---------------------------------------------------------------
  // interrupt pin
  // ---------------------------------------------------------------
  logic pending;
  logic irq_armed_q;
  logic irq_low_q;
  logic irq_oe_n_q;

  assign pending = |stat_pend;

  always_ff @(posedge sys_clk) begin
    if (rst)
      irq_armed_q <= 1'b0;
    else if (pending)
      irq_armed_q <= 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_low_q  <= 1'b0;
      irq_oe_n_q <= 1'b1;
    end else begin
      irq_low_q  <= pending;
      irq_oe_n_q <= !(pending ||
                      (irq_drive_high_select && irq_armed_q));
    end
  end

  assign irq_n_out  = !irq_low_q;
  assign irq_n_oe_n = rst || irq_oe_n_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_split_read;
    state_q == hpp_pkg::ST_IDLE && is_split && !pin_q.cs_n &&
    !pin_q.rd_ds_n;
  endsequence
  sequence s_strobe_read;
    state_q == hpp_pkg::ST_IDLE && is_strobe && !pin_q.cs_n &&
    !pin_q.rd_ds_n && pin_q.wr_rw_n;
  endsequence
  sequence s_write_done;
    state_q == hpp_pkg::ST_WRITE && wr_act ##1 !wr_act;
  endsequence

  property p_split_read;
    @(posedge sys_clk) disable iff (rst)
    s_split_read |=> reg_rd ##1 !reg_rd;
  endproperty
  a_split_read: assert property (p_split_read)
    else $error("split read strobe gave no read pulse");

  property p_strobe_read;
    @(posedge sys_clk) disable iff (rst)
    s_strobe_read |=> reg_rd && state_q == hpp_pkg::ST_READ;
  endproperty
  a_strobe_read: assert property (p_strobe_read)
    else $error("data strobe read gave no read pulse");

  property p_write_pulse;
    @(posedge sys_clk) disable iff (rst)
    s_write_done |=> reg_wr && reg_addr == $past(reg_addr) ##1 !reg_wr;
  endproperty
  a_write_pulse: assert property (p_write_pulse)
    else $error("write strobe end gave no single write pulse");

  property p_cs_ignore;
    @(posedge sys_clk) disable iff (rst)
    pin_q.cs_n |-> !rd_start && data_oe_n ##1 !reg_wr || $past(wr_end);
  endproperty
  a_cs_ignore: assert property (p_cs_ignore)
    else $error("access taken with chip select high");

  property p_rd_drive;
    @(posedge sys_clk)
    !data_oe_n |-> !pin_q.cs_n && rd_act && !rst;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("data bus driven outside a read");

  property p_reset_hiz;
    @(posedge sys_clk)
    rst |-> data_oe_n && irq_n_oe_n;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz)
    else $error("host bus driven during reset");

  property p_irq_low;
    @(posedge sys_clk) disable iff (rst)
    pending |=> !irq_n_out && !irq_n_oe_n;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt not asserted for pending source");

  property p_irq_float;
    @(posedge sys_clk) disable iff (rst)
    !pending && (!irq_drive_high_select || !irq_armed_q)
    |=> irq_n_oe_n;
  endproperty
  a_irq_float: assert property (p_irq_float)
    else $error("inactive interrupt driven while floating mode");

  property p_irq_drive_high;
    @(posedge sys_clk) disable iff (rst)
    !pending && irq_drive_high_select && irq_armed_q
    |=> !irq_n_oe_n && irq_n_out;
  endproperty
  a_irq_drive_high: assert property (p_irq_drive_high)
    else $error("inactive interrupt not driven high");

  property p_irq_idle_after_reset;
    @(posedge sys_clk) disable iff (rst)
    $fell(rst) ##0 !pending [*2] |-> irq_n_oe_n;
  endproperty
  a_irq_idle_after_reset: assert property (p_irq_idle_after_reset)
    else $error("interrupt pin left high impedance too early");

endmodule

// ---- hpp_pkg.sv ----
// package for the parallel host port
package hpp_pkg;

  // ---------------------------------------------------------------
  // bus style codes
  // ---------------------------------------------------------------
  localparam logic [1:0] STYLE_SPLIT  = 2'h0;
  localparam logic [1:0] STYLE_STROBE = 2'h1;

  // ---------------------------------------------------------------
  // widths and map
  // ---------------------------------------------------------------
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 8;
  localparam int          STAT_REGS  = 2;
  localparam logic [7:0]  STAT_BASE  = 8'hF0;
  localparam logic [7:0]  STAT_RST   = 8'h00;

  // ---------------------------------------------------------------
  // pin bundle and state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       cs_n;
    logic       rd_ds_n;
    logic       wr_rw_n;
    logic [1:0] bus_style_select;
    logic [7:0] addr;
    logic [7:0] data;
  } hpp_pins_s;

  localparam hpp_pins_s PINS_IDLE = 21'h1C0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_READ  = 3'h2,
    ST_WRITE = 3'h4
  } hpp_state_e;

endpackage

// ---- hpp_host_model.sv ----
// host microprocessor model driving the parallel host port pins
`timescale 1ns/1ps

module hpp_host_model (
  // clock
  input  wire logic       sys_clk,
  // device side of the data pins
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n,
  // host pins
  output      logic [7:0] addr,
  output      logic [7:0] data_in,
  output      logic       cs_n,
  output      logic       rd_data_strobe_n,
  output      logic       wr_rw_n,
  output      logic [1:0] bus_style_select,
  // read result
  output      logic       rd_done,
  output      logic [7:0] rd_val
);
  logic [7:0] host_d;
  logic       host_oe;
  logic [7:0] last_q;

  initial begin
    addr             = 8'h00;
    host_d           = 8'h00;
    host_oe          = 1'b0;
    last_q           = 8'h00;
    cs_n             = 1'b1;
    rd_data_strobe_n = 1'b1;
    wr_rw_n          = 1'b1;
    bus_style_select = 2'h0;
    rd_done          = 1'b0;
    rd_val           = 8'h00;
  end

  // ------------------------------------------------
  // data wire: device, host, else changing garbage
  // ------------------------------------------------
  always_comb begin
    if (data_oe_n === 1'b0) begin
      data_in = data_out;
    end else if (host_oe) begin
      data_in = host_d;
    end else begin
      data_in = ~last_q;
    end
  end

  always @(posedge sys_clk) begin
    last_q <= data_in;
  end

  // ------------------------------------------------
  // one bus cycle
  // ------------------------------------------------
  task automatic access(input logic [1:0] st, input logic wr,
                        input logic sel, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge sys_clk);
    bus_style_select <= st;
    addr             <= a;
    host_d           <= d;
    host_oe          <= wr;
    cs_n             <= !sel;
    wr_rw_n          <= st[0] ? !wr : 1'b1;
    repeat (2) @(posedge sys_clk);
    if (wr && !st[0]) begin
      wr_rw_n <= 1'b0;
    end else begin
      rd_data_strobe_n <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    rd_val           <= data_in;
    rd_done          <= !wr && sel && !st[1];
    rd_data_strobe_n <= 1'b1;
    if (!st[0]) begin
      wr_rw_n <= 1'b1;
    end
    @(posedge sys_clk);
    rd_done <= 1'b0;
    cs_n    <= 1'b1;
    @(posedge sys_clk);
    host_oe <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule

// ---- host_parallel_bus_port_tb.sv ----
// self-checking testbench for the parallel host port
`timescale 1ns/1ps

module host_parallel_bus_port_tb;
  logic        sys_clk;
  logic        rst;
  logic [7:0]  addr, data_in, data_out, reg_addr, reg_wdata;
  logic [7:0]  rd_val, a, d;
  logic        data_oe_n, cs_n, rd_data_strobe_n, wr_rw_n;
  logic        irq_n_out, irq_n_oe_n, reg_wr, reg_rd, rd_done;
  logic        irq_drive_high_select;
  logic [1:0]  bus_style_select;
  logic [15:0] stat_event, stat_mask;
  logic [7:0]  regmem [256];
  logic [16:0] exp_q [$];
  int          fails, checks_done, cycles, seed;
  int          oe_cnt, oe_base, rd_cnt;

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  hpp_host_port DUT (.sys_clk(sys_clk), .rst(rst), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .cs_n(cs_n), .rd_data_strobe_n(rd_data_strobe_n), .wr_rw_n(wr_rw_n),
    .bus_style_select(bus_style_select), .irq_n_out(irq_n_out),
    .irq_n_oe_n(irq_n_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(regmem[reg_addr]),
    .stat_event(stat_event), .stat_mask(stat_mask),
    .irq_drive_high_select(irq_drive_high_select));

  hpp_host_model u_host (.sys_clk(sys_clk), .data_out(data_out),
    .data_oe_n(data_oe_n), .addr(addr), .data_in(data_in), .cs_n(cs_n),
    .rd_data_strobe_n(rd_data_strobe_n), .wr_rw_n(wr_rw_n),
    .bus_style_select(bus_style_select), .rd_done(rd_done),
    .rd_val(rd_val));

  // ------------------------------------------------
  // checking and closing
  // ------------------------------------------------
  task automatic chk(input string what, input logic [16:0] e,
                     input logic [16:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic stat_read(input logic [7:0] ra, input logic [7:0] e);
    exp_q.push_back({9'h000, e});
    u_host.access(hpp_pkg::STYLE_SPLIT, 1'b0, 1'b1, ra, 8'h00);
  endtask

  // ------------------------------------------------
  // register file, watcher, timeout
  // ------------------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (reg_wr === 1'b1) begin
      regmem[reg_addr] <= reg_wdata;
      if (exp_q.size() == 0) chk("stray write", 17'h0, 17'h1FFFF);
      else chk("write", exp_q.pop_front(), {1'b1, reg_addr, reg_wdata});
    end
    if (rd_done === 1'b1 && exp_q.size() != 0)
      chk("read", exp_q.pop_front(), {9'h000, rd_val});
    if (data_oe_n === 1'b0) oe_cnt <= oe_cnt + 1;
    if (reg_rd === 1'b1) rd_cnt <= rd_cnt + 1;
    if (cycles == 6000) begin
      fails++;
      complete_run();
    end
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    rst = 1'b1;
    seed = 42;
    stat_event = 16'h0000;
    stat_mask = 16'h00FF;
    irq_drive_high_select = 1'b1;
    repeat (16) @(posedge sys_clk);
    chk("data enable in reset", 17'h1, {16'h0, data_oe_n});
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("irq enable after reset", 17'h1, {16'h0, irq_n_oe_n});
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 3; i++) begin
        a = 8'($random(seed)) & 8'h7F;
        d = 8'($random(seed));
        exp_q.push_back({1'b1, a, d});
        u_host.access(2'(s), 1'b1, 1'b1, a, d);
        exp_q.push_back({9'h000, d});
        u_host.access(2'(s), 1'b0, 1'b1, a, 8'h00);
        chk("idle data enable", 17'h1, {16'h0, data_oe_n});
      end
    end
    oe_base = oe_cnt;
    u_host.access(hpp_pkg::STYLE_SPLIT, 1'b1, 1'b0, 8'h05, 8'hA5);
    u_host.access(hpp_pkg::STYLE_STROBE, 1'b0, 1'b0, 8'h05, 8'h00);
    u_host.access(2'h2, 1'b1, 1'b1, 8'h06, 8'h5A);
    chk("drive while refused", 17'(oe_base), 17'(oe_cnt));
    @(posedge sys_clk) stat_event <= 16'h0008;
    @(posedge sys_clk) stat_event <= 16'h0000;
    repeat (3) @(posedge sys_clk);
    chk("irq pending", 17'h0, {15'h0, irq_n_oe_n, irq_n_out});
    stat_read(8'hF0, 8'h08);
    chk("irq idle high", 17'h1, {15'h0, irq_n_oe_n, irq_n_out});
    stat_read(8'hF0, 8'h00);
    irq_drive_high_select <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("irq float", 17'h1, {16'h0, irq_n_oe_n});
    @(posedge sys_clk) stat_event <= 16'h0100;
    @(posedge sys_clk) stat_event <= 16'h0000;
    repeat (3) @(posedge sys_clk);
    chk("masked irq", 17'h1, {16'h0, irq_n_oe_n});
    stat_read(8'hF1, 8'h01);
    @(posedge sys_clk) stat_event <= 16'h0002;
    stat_read(8'hF0, 8'h02);
    stat_event <= 16'h0000;
    stat_read(8'hF0, 8'h02);
    stat_read(8'hF0, 8'h00);
    irq_drive_high_select <= 1'b1;
    fork
      u_host.access(hpp_pkg::STYLE_SPLIT, 1'b0, 1'b1, 8'h10, 8'h00);
    join_none
    repeat (10) @(posedge sys_clk);
    chk("read drive", 17'h0, {15'h0, data_oe_n, irq_n_oe_n});
    rst <= 1'b1;
    @(negedge sys_clk);
    chk("enables in reset", 17'h3, {15'h0, data_oe_n, irq_n_oe_n});
    repeat (14) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("irq after reset", 17'h1, {16'h0, irq_n_oe_n});
    chk("read pulses", 17'h0000D, 17'(rd_cnt));
    complete_run();
  end
endmodule
